// ==== src/aidr_pkg.sv ====
// aidr_pkg: constants and types of the analog input diagnostic record
// assumes a 40 MHz core clock and a byte-wide record read port
package aidr_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_PERIOD_NS = 1000; // one microsecond
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

	// ****************************************
	// access keys
	// ****************************************
	localparam logic [15:0] RSET_FULL = 16'h0001;
	localparam logic [15:0] RSET_SHORT = 16'h0000;
	localparam logic [15:0] OBJ_FULL = 16'h2f01;
	localparam logic [15:0] OBJ_SHORT = 16'h2f00;
	localparam logic [15:0] SUB_INDEX = 16'h5005;
	localparam logic [7:0] SUB_FIRST = 8'h02;
	localparam logic [7:0] SUB_RSVD_LAST = 8'h11;
	localparam logic [7:0] SUB_STAMP = 8'h13;

	// ****************************************
	// record layout (byte positions)
	// ****************************************
	localparam logic [4:0] BYTE_SUMMARY = 5'h00;
	localparam logic [4:0] BYTE_MODINFO = 5'h01;
	localparam logic [4:0] BYTE_RSVD_ERR = 5'h02;
	localparam logic [4:0] BYTE_EXT = 5'h03;
	localparam logic [4:0] BYTE_KIND = 5'h04;
	localparam logic [4:0] BYTE_BITS = 5'h05;
	localparam logic [4:0] BYTE_COUNT = 5'h06;
	localparam logic [4:0] BYTE_GROUP = 5'h07;
	localparam logic [4:0] BYTE_CH0 = 5'h08;
	localparam logic [4:0] BYTE_STAMP = 5'h10;
	localparam logic [4:0] REC_SHORT_LEN = 5'h04;
	localparam logic [4:0] REC_FULL_LEN = 5'h14;

	// ****************************************
	// constant bytes and field positions
	// ****************************************
	localparam logic [7:0] MODINFO_VAL = 8'h15; // class 0101b, chan info
	localparam logic [7:0] KIND_VAL = 8'h71; // analog input
	localparam logic [7:0] BITS_VAL = 8'h08;
	localparam logic [7:0] COUNT_VAL = 8'h04;
	localparam int SUM_FAIL = 0;
	localparam int SUM_INT = 1;
	localparam int SUM_EXT = 2;
	localparam int SUM_CHAN = 3;
	localparam int SUM_AUX = 4;
	localparam int SUM_PARAM = 7;
	localparam int EXT_BUFOVF = 3;
	localparam int EXT_COMM = 4;
	localparam int CH_PARAM = 0;
	localparam int CH_WIRE = 4;
	localparam int CH_UNDER = 6;
	localparam int CH_OVER = 7;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		AIDR_PATH_RSET,
		AIDR_PATH_OBJ,
		AIDR_PATH_SUB
	} aidr_path_e;

	typedef struct packed {
		logic [5:0] presc;
		logic [31:0] ticker;
		logic [7:0] summary;
		logic [7:0] ext;
		logic [3:0][7:0] ch;
		logic [31:0] stamp;
		logic [7:0] rd_data;
		logic rd_ack;
		logic rd_err;
	} aidr_state_s;
endpackage

// ==== src/aidr_diag_record.sv ====
// aidr_diag_record: diagnostic record of a four-channel analog input
// assumes fault inputs come from logic on core_clk_i
// Behaviour
// RULE1 - no diagnostic interrupt; the record is only read
// RULE2 - on error, light the channel indicator and log it in the record
// RULE3 - record set 01h returns the whole record, 00h the first four bytes
// RULE4 - object 2F01h returns the whole record, 2F00h the first four bytes
// RULE5 - index 5005h, one subindex per field from 02h upward
// RULE6 - summary bits 0..3: module fail, internal, external, channel error
// RULE7 - summary bit 4 aux supply missing, bit 7 parameter error
// RULE8 - module info bits 3..0 hold class 0101b, bits 7..5 zero
// RULE9 - module info bit 4 set since channel bytes are present
// RULE10 - extended byte bit 3 buffer overflow, bit 4 communication error
// RULE11 - channel type byte holds 71h, analog input
// RULE12 - diagnostic bits per channel reads 08h
// RULE13 - channel count reads 04h
// RULE14 - channel group byte bit n marks an error on channel n
// RULE15 - channel byte bit 0 marks a channel parameter error
// RULE16 - channel byte bit 4 marks a wire break
// RULE17 - channel byte bit 6 underflow, bit 7 overflow
// RULE18 - on a new diagnostic event store the microsecond ticker
// RULE19 - ticker starts at zero on power-on, steps once per microsecond
// RULE20 - ticker wraps from all ones to zero
// RULE21 - record is read only; reserved bits and bytes read zero
// RULE22 - channel flag follows groups, groups follow channel bytes
`timescale 1ns/1ps
`default_nettype none
module aidr_diag_record
	import aidr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic module_fail_i,
	input wire logic internal_err_i,
	input wire logic external_err_i,
	input wire logic aux_missing_i,
	input wire logic param_err_i,
	input wire logic diag_buf_ovf_i,
	input wire logic comm_err_i,
	input wire logic [3:0] ch_param_err_i,
	input wire logic [3:0] ch_wire_break_i,
	input wire logic [3:0] ch_underflow_i,
	input wire logic [3:0] ch_overflow_i,
	input wire logic rd_req_i,
	input wire aidr_path_e rd_path_i,
	input wire logic [15:0] rd_key_i,
	input wire logic [7:0] rd_sub_i,
	input wire logic [4:0] rd_byte_i,
	output logic rd_ack_o,
	output logic rd_err_o,
	output logic [7:0] rd_data_o,
	output logic [3:0] ch_led_o,
	output logic [31:0] us_ticker_o
);
	aidr_state_s st_r;
	aidr_state_s st_nxt;
	logic [7:0] led_grp;

	// ****************************************
	// helpers
	// ****************************************
	// group byte from the channel bytes
	function automatic logic [7:0] group_of(input logic [3:0][7:0] ch);
		logic [7:0] g;
		g = 8'h00;
		for (int i = 0; i < 4; i++) begin
			g[i] = |ch[i]; // RULE14 RULE22
		end
		return g;
	endfunction

	// one byte of the record by its position
	function automatic logic [7:0] rec_byte(input aidr_state_s s,
		input logic [4:0] idx);
		logic [7:0] b;
		b = 8'h00; // RULE21
		if (idx == BYTE_SUMMARY) begin
			b = s.summary;
		end else if (idx == BYTE_MODINFO) begin
			b = MODINFO_VAL; // RULE8 RULE9
		end else if (idx == BYTE_RSVD_ERR) begin
			b = 8'h00;
		end else if (idx == BYTE_EXT) begin
			b = s.ext;
		end else if (idx == BYTE_KIND) begin
			b = KIND_VAL; // RULE11
		end else if (idx == BYTE_BITS) begin
			b = BITS_VAL; // RULE12
		end else if (idx == BYTE_COUNT) begin
			b = COUNT_VAL; // RULE13
		end else if (idx == BYTE_GROUP) begin
			b = group_of(s.ch);
		end else if (idx >= BYTE_CH0 && idx < BYTE_CH0 + 5'h04) begin
			b = s.ch[idx[1:0]];
		end else if (idx >= BYTE_STAMP && idx < REC_FULL_LEN) begin
			b = s.stamp[8 * idx[1:0] +: 8];
		end
		return b;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	// ticker, fault capture, read answer
	always_comb begin
		logic [7:0] grp;
		logic [47:0] flags_old;
		logic [47:0] flags_new;
		logic [4:0] idx;
		logic hit;
		grp = 8'h00;
		flags_old = '0;
		flags_new = '0;
		idx = 5'h00;
		hit = 1'b0;
		st_nxt = st_r;
		// microsecond ticker
		if (st_r.presc == TICK_LAST) begin
			st_nxt.presc = 6'h00;
			st_nxt.ticker = st_r.ticker + 32'h1; // RULE19 RULE20
		end else begin
			st_nxt.presc = st_r.presc + 6'h01;
		end
		// per channel bytes, reserved bits zero
		for (int i = 0; i < 4; i++) begin
			st_nxt.ch[i] = 8'h00;
			st_nxt.ch[i][CH_PARAM] = ch_param_err_i[i]; // RULE15
			st_nxt.ch[i][CH_WIRE] = ch_wire_break_i[i]; // RULE16
			st_nxt.ch[i][CH_UNDER] = ch_underflow_i[i]; // RULE17
			st_nxt.ch[i][CH_OVER] = ch_overflow_i[i]; // RULE17
		end
		grp = group_of(st_nxt.ch);
		// summary byte
		st_nxt.summary = 8'h00;
		st_nxt.summary[SUM_FAIL] = module_fail_i; // RULE6
		st_nxt.summary[SUM_INT] = internal_err_i; // RULE6
		st_nxt.summary[SUM_EXT] = external_err_i; // RULE6
		st_nxt.summary[SUM_CHAN] = |grp; // RULE6 RULE22
		st_nxt.summary[SUM_AUX] = aux_missing_i; // RULE7
		st_nxt.summary[SUM_PARAM] = param_err_i; // RULE7
		// extended byte
		st_nxt.ext = 8'h00;
		st_nxt.ext[EXT_BUFOVF] = diag_buf_ovf_i; // RULE10
		st_nxt.ext[EXT_COMM] = comm_err_i; // RULE10
		// a newly raised flag timestamps the record
		flags_old = {st_r.summary, st_r.ext, st_r.ch};
		flags_new = {st_nxt.summary, st_nxt.ext, st_nxt.ch};
		if (|(flags_new & ~flags_old)) begin
			st_nxt.stamp = st_r.ticker; // RULE18
		end
		// read decode, answered next cycle
		st_nxt.rd_ack = rd_req_i;
		if (rd_req_i) begin
			case (rd_path_i)
				AIDR_PATH_RSET: begin
					idx = rd_byte_i;
					hit = (rd_key_i == RSET_FULL && idx < REC_FULL_LEN) ||
						(rd_key_i == RSET_SHORT && idx < REC_SHORT_LEN); // RULE3
				end
				AIDR_PATH_OBJ: begin
					idx = rd_byte_i;
					hit = (rd_key_i == OBJ_FULL && idx < REC_FULL_LEN) ||
						(rd_key_i == OBJ_SHORT && idx < REC_SHORT_LEN); // RULE4
				end
				AIDR_PATH_SUB: begin
					if (rd_key_i == SUB_INDEX) begin
						if (rd_sub_i >= SUB_FIRST && rd_sub_i <= SUB_RSVD_LAST) begin
							idx = 5'(rd_sub_i - SUB_FIRST); // RULE5
							hit = 1'b1;
						end else if (rd_sub_i == SUB_STAMP) begin
							idx = BYTE_STAMP + {3'h0, rd_byte_i[1:0]}; // RULE5
							hit = 1'b1;
						end
					end
				end
				default: begin
					hit = 1'b0;
				end
			endcase
			st_nxt.rd_err = ~hit;
			st_nxt.rd_data = hit ? rec_byte(st_r, idx) : 8'h00;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	// all state in one register
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0; // RULE19
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs; no interrupt output exists
	assign rd_ack_o = st_r.rd_ack; // RULE1
	assign rd_err_o = st_r.rd_err;
	assign rd_data_o = st_r.rd_data;
	assign led_grp = group_of(st_r.ch);
	assign ch_led_o = led_grp[3:0]; // RULE2
	assign us_ticker_o = st_r.ticker;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	a_ticker_step: assert property ( // RULE19
		st_r.presc == TICK_LAST |=> st_r.ticker == $past(st_r.ticker) + 32'h1)
		else $error("ticker did not step");
	a_ticker_hold: assert property ( // RULE19
		st_r.presc != TICK_LAST |=> $stable(st_r.ticker))
		else $error("ticker stepped early");
	a_ticker_wrap: assert property ( // RULE20
		st_r.presc == TICK_LAST |=>
		(st_r.ticker == 32'h0) == ($past(st_r.ticker) == 32'hffffffff))
		else $error("ticker did not wrap");
	a_led_channel: assert property ( // RULE2
		ch_overflow_i[0] |=> ch_led_o[0] && rd_ack_o == $past(rd_req_i))
		else $error("led not lit on error");
	a_chan_bits: assert property ( // RULE16
		ch_wire_break_i[2] && !ch_underflow_i[2] |=> st_r.ch[2][CH_WIRE] &&
		!st_r.ch[2][CH_UNDER])
		else $error("channel bits wrong");
	a_summary_chan: assert property ( // RULE22
		st_r.summary[SUM_CHAN] == (|ch_led_o))
		else $error("summary channel flag wrong");
	a_stamp_take: assert property ( // RULE18
		!module_fail_i ##1 module_fail_i |=> st_r.stamp == $past(st_r.ticker))
		else $error("stamp not taken");
	a_short_set: assert property ( // RULE3
		rd_req_i && rd_path_i == AIDR_PATH_RSET && rd_key_i == RSET_SHORT &&
		rd_byte_i >= REC_SHORT_LEN |=> rd_ack_o && rd_err_o)
		else $error("short record overrun not refused");
	a_bits_const: assert property ( // RULE12
		rd_req_i && rd_path_i == AIDR_PATH_SUB && rd_key_i == SUB_INDEX &&
		rd_sub_i == 8'h07 |=> rd_data_o == BITS_VAL && !rd_err_o)
		else $error("bits per channel wrong");
	a_presc_range: assert property ( // RULE19
		st_r.presc <= TICK_LAST)
		else $error("prescaler out of range");
	a_led_wire: assert property ( // RULE2
		ch_wire_break_i[3] |=> ch_led_o[3])
		else $error("led not lit on wire break");
	a_stamp_chan: assert property ( // RULE18
		!ch_wire_break_i[1] ##1 ch_wire_break_i[1]
		|=> st_r.stamp == $past(st_r.ticker))
		else $error("stamp not taken on channel event");

	// ****************************************
	// read port checks
	// ****************************************
	a_ack_taken: assert property ( // RULE3
		rd_req_i |=> rd_ack_o)
		else $error("read not answered");
	a_ack_single: assert property ( // RULE3
		!rd_req_i |=> !rd_ack_o)
		else $error("answer without request");
	a_data_hold: assert property ( // RULE21
		!rd_req_i |=> $stable(rd_data_o) && $stable(rd_err_o))
		else $error("read data moved without request");
	a_err_zero: assert property ( // RULE21
		rd_ack_o && rd_err_o |-> rd_data_o == 8'h00)
		else $error("refused read returned data");
	a_full_set: assert property ( // RULE3
		rd_req_i && rd_path_i == AIDR_PATH_RSET && rd_key_i == RSET_FULL &&
		rd_byte_i < REC_FULL_LEN |=> rd_ack_o && !rd_err_o)
		else $error("full record read refused");
	a_obj_full: assert property ( // RULE4
		rd_req_i && rd_path_i == AIDR_PATH_OBJ && rd_key_i == OBJ_FULL &&
		rd_byte_i < REC_FULL_LEN |=> rd_ack_o && !rd_err_o)
		else $error("full object read refused");
	a_obj_short: assert property ( // RULE4
		rd_req_i && rd_path_i == AIDR_PATH_OBJ && rd_key_i == OBJ_SHORT &&
		rd_byte_i >= REC_SHORT_LEN |=> rd_ack_o && rd_err_o)
		else $error("short object overrun not refused");
	a_sub_key: assert property ( // RULE5
		rd_req_i && rd_path_i == AIDR_PATH_SUB && rd_key_i != SUB_INDEX
		|=> rd_ack_o && rd_err_o)
		else $error("foreign index not refused");
	a_sub_gap: assert property ( // RULE5
		rd_req_i && rd_path_i == AIDR_PATH_SUB && rd_key_i == SUB_INDEX &&
		rd_sub_i == SUB_RSVD_LAST + 8'h01 |=> rd_ack_o && rd_err_o)
		else $error("unmapped subindex not refused");
	a_stamp_byte: assert property ( // RULE5
		rd_req_i && rd_path_i == AIDR_PATH_SUB && rd_key_i == SUB_INDEX &&
		rd_sub_i == SUB_STAMP && rd_byte_i[1:0] == 2'h0
		|=> rd_data_o == $past(st_r.stamp[7:0]) && !rd_err_o)
		else $error("stamp low byte wrong");

	// ****************************************
	// record content checks
	// ****************************************
	a_modinfo_short: assert property ( // RULE8
		rd_req_i && rd_path_i == AIDR_PATH_OBJ && rd_key_i == OBJ_SHORT &&
		rd_byte_i == BYTE_MODINFO |=> rd_data_o == MODINFO_VAL && !rd_err_o)
		else $error("module info byte wrong");
	a_kind_byte: assert property ( // RULE11
		rd_req_i && rd_path_i == AIDR_PATH_RSET && rd_key_i == RSET_FULL &&
		rd_byte_i == BYTE_KIND |=> rd_data_o == KIND_VAL)
		else $error("channel type byte wrong");
	a_count_byte: assert property ( // RULE13
		rd_req_i && rd_path_i == AIDR_PATH_RSET && rd_key_i == RSET_FULL &&
		rd_byte_i == BYTE_COUNT |=> rd_data_o == COUNT_VAL)
		else $error("channel count byte wrong");
	a_rsvd_byte: assert property ( // RULE21
		rd_req_i && rd_path_i == AIDR_PATH_RSET && rd_key_i == RSET_FULL &&
		rd_byte_i == BYTE_RSVD_ERR |=> rd_data_o == 8'h00 && !rd_err_o)
		else $error("reserved byte not zero");
	a_group_byte: assert property ( // RULE14
		rd_req_i && rd_path_i == AIDR_PATH_RSET && rd_key_i == RSET_FULL &&
		rd_byte_i == BYTE_GROUP |=> rd_data_o == $past(led_grp) &&
		rd_data_o[7:4] == 4'h0)
		else $error("channel group byte wrong");
	a_sum_module: assert property ( // RULE6
		1'b1 |=> st_r.summary[SUM_FAIL] == $past(module_fail_i) &&
		st_r.summary[SUM_INT] == $past(internal_err_i) &&
		st_r.summary[SUM_EXT] == $past(external_err_i))
		else $error("summary module bits wrong");
	a_sum_supply: assert property ( // RULE7
		1'b1 |=> st_r.summary[SUM_AUX] == $past(aux_missing_i) &&
		st_r.summary[SUM_PARAM] == $past(param_err_i) &&
		st_r.summary[SUM_PARAM-1:SUM_AUX+1] == 2'b00)
		else $error("summary supply or parameter bit wrong");
	a_ext_bits: assert property ( // RULE10
		1'b1 |=> st_r.ext[EXT_BUFOVF] == $past(diag_buf_ovf_i) &&
		st_r.ext[EXT_COMM] == $past(comm_err_i) &&
		st_r.ext[EXT_BUFOVF-1:0] == 3'b000 &&
		st_r.ext[7:EXT_COMM+1] == 3'b000)
		else $error("extended byte wrong");
	a_chan_param: assert property ( // RULE15
		1'b1 |=> st_r.ch[0][CH_PARAM] == $past(ch_param_err_i[0]) &&
		st_r.ch[0][CH_WIRE-1:CH_PARAM+1] == 3'b000 &&
		!st_r.ch[0][CH_UNDER-1])
		else $error("channel parameter bit wrong");
	a_chan_range: assert property ( // RULE17
		1'b1 |=> st_r.ch[3][CH_UNDER] == $past(ch_underflow_i[3]) &&
		st_r.ch[3][CH_OVER] == $past(ch_overflow_i[3]))
		else $error("channel range bits wrong");

	c_rset_read: cover property (
		rd_req_i && rd_path_i == AIDR_PATH_RSET ##1 rd_ack_o && !rd_err_o);
	c_obj_read: cover property (
		rd_req_i && rd_path_i == AIDR_PATH_OBJ ##1 rd_ack_o && !rd_err_o);
	c_sub_stamp: cover property (
		rd_req_i && rd_sub_i == SUB_STAMP ##1 rd_ack_o && !rd_err_o);
	c_event: cover property (!ch_wire_break_i[1] ##1 ch_wire_break_i[1]);
	c_refused: cover property (rd_req_i ##1 rd_ack_o && rd_err_o);
endmodule // aidr_diag_record
`default_nettype wire

// ==== tb/aidr_reader_model.sv ====
// aidr_reader_model: head-end reader of the diagnostic record
// assumes rd is called at a falling edge of core_clk_i
`timescale 1ns/1ps
`default_nettype none
module aidr_reader_model
	import aidr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rd_ack_i,
	input wire logic rd_err_i,
	input wire logic [7:0] rd_data_i,
	output logic rd_req_o,
	output var aidr_path_e rd_path_o,
	output logic [15:0] rd_key_o,
	output logic [7:0] rd_sub_o,
	output logic [4:0] rd_byte_o
);
	// one byte: one-cycle request, fields held until the answer
	task automatic rd(input aidr_path_e p, input logic [15:0] k,
		input logic [7:0] s, input logic [4:0] b,
		output logic [8:0] r, output bit ok);
		ok = 0;
		r = 9'h000;
		rd_path_o = p;
		rd_key_o = k;
		rd_sub_o = s;
		rd_byte_o = b;
		rd_req_o = 1'b1;
		// the answer stands in the cycle after the taking edge
		@(negedge core_clk_i);
		rd_req_o = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (rd_ack_i === 1'b1) begin
				ok = 1;
				r = {rd_err_i, rd_data_i};
			end else begin
				@(negedge core_clk_i);
			end
		end
		// let an edge pass before the next request
		@(negedge core_clk_i);
	endtask
	// idle request lines
	initial begin
		rd_req_o = 1'b0;
		rd_path_o = AIDR_PATH_RSET;
		rd_key_o = 16'h0000;
		rd_sub_o = 8'h00;
		rd_byte_o = 5'h00;
	end
endmodule // aidr_reader_model
`default_nettype wire

// ==== tb/tb.sv ====
// tb: self-checking bench of the diagnostic record
// assumes a reader model on the read port, faults driven here
`timescale 1ns/1ps
`default_nettype none
module tb;
	import aidr_pkg::*;
	logic core_clk_i, nrst_i, ack, err, req;
	logic [6:0] sm;
	logic [3:0][3:0] cf;
	logic [7:0] data, sub;
	logic [3:0] led;
	logic [31:0] tick, ne;
	logic [15:0] key;
	logic [4:0] byt;
	aidr_path_e path;
	int n_mismatch, samples_checked;
	aidr_diag_record uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.module_fail_i(sm[0]), .internal_err_i(sm[1]),
		.external_err_i(sm[2]), .aux_missing_i(sm[3]),
		.param_err_i(sm[4]), .diag_buf_ovf_i(sm[5]), .comm_err_i(sm[6]),
		.ch_param_err_i(cf[0]), .ch_wire_break_i(cf[1]),
		.ch_underflow_i(cf[2]), .ch_overflow_i(cf[3]), .rd_req_i(req),
		.rd_path_i(path), .rd_key_i(key), .rd_sub_i(sub), .rd_byte_i(byt),
		.rd_ack_o(ack), .rd_err_o(err), .rd_data_o(data), .ch_led_o(led),
		.us_ticker_o(tick));
	aidr_reader_model rdr (.core_clk_i(core_clk_i), .rd_ack_i(ack),
		.rd_err_i(err), .rd_data_i(data), .rd_req_o(req),
		.rd_path_o(path), .rd_key_o(key), .rd_sub_o(sub), .rd_byte_o(byt));
	// clock and edge count since reset release
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i or negedge nrst_i)
		if (!nrst_i) ne <= 32'h0;
		else ne <= ne + 32'h1;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// read one byte and compare {err, data}
	task automatic rx(aidr_path_e p, logic [15:0] k, logic [7:0] s,
		logic [4:0] b, logic [8:0] e);
		logic [8:0] r;
		bit ok;
		rdr.rd(p, k, s, b, r, ok);
		if (!ok) begin
			n_mismatch++;
			$display("[FAIL] ack exp 1 seen 0");
			tally_and_finish();
		end else begin
			chk($sformatf("rd %h/%h/%h", k, s, b), {23'h0, r}, {23'h0, e});
		end
	endtask
	// fixed bytes over record set and subindex paths
	task automatic t_const();
		logic [7:0] e[20];
		e = '{default: 8'h00};
		e[1] = 8'h15;
		e[4] = 8'h71;
		e[5] = 8'h08;
		e[6] = 8'h04;
		for (int b = 0; b < 20; b++)
			rx(AIDR_PATH_RSET, 16'h0001, 8'h00, 5'(b), {1'b0, e[b]});
		for (int s = 2; s < 18; s++)
			rx(AIDR_PATH_SUB, 16'h5005, 8'(s), 5'h0, {1'b0, e[s-2]});
		$display("t_const done");
	endtask
	// short paths and refused keys
	task automatic t_refuse();
		rx(AIDR_PATH_RSET, 16'h0000, 8'h00, 5'h01, 9'h015);
		rx(AIDR_PATH_RSET, 16'h0000, 8'h00, 5'h04, 9'h100);
		rx(AIDR_PATH_RSET, 16'h0002, 8'h00, 5'h00, 9'h100);
		rx(AIDR_PATH_OBJ, 16'h2f01, 8'h00, 5'h05, 9'h008);
		rx(AIDR_PATH_OBJ, 16'h2f00, 8'h00, 5'h01, 9'h015);
		rx(AIDR_PATH_OBJ, 16'h2f00, 8'h00, 5'h04, 9'h100);
		rx(AIDR_PATH_OBJ, 16'h2f02, 8'h00, 5'h00, 9'h100);
		rx(AIDR_PATH_SUB, 16'h5005, 8'h12, 5'h00, 9'h100);
		rx(AIDR_PATH_SUB, 16'h5006, 8'h07, 5'h00, 9'h100);
		$display("t_refuse done");
	endtask
	// module level faults one at a time
	task automatic t_summary();
		int bp[7] = '{0, 1, 2, 4, 7, 3, 4};
		for (int i = 0; i < 7; i++) begin
			sm = 7'h01 << i;
			@(negedge core_clk_i);
			rx(AIDR_PATH_RSET, 16'h0001, 8'h00, (i < 5) ? 5'h00 : 5'h03,
				{1'b0, 8'h01 << bp[i]});
		end
		sm = 7'h00;
		$display("t_summary done");
	endtask
	// every channel fault kind on every channel
	task automatic t_chan();
		int bp[4] = '{0, 4, 6, 7};
		for (int c = 0; c < 4; c++)
			for (int k = 0; k < 4; k++) begin
				cf = '0;
				cf[k][c] = 1'b1;
				@(negedge core_clk_i);
				chk("led", {28'h0, led}, 32'h1 << c);
				rx(AIDR_PATH_RSET, 16'h0001, 8'h00, 5'(8 + c),
					{1'b0, 8'h01 << bp[k]});
				rx(AIDR_PATH_RSET, 16'h0001, 8'h00, 5'h07,
					{1'b0, 8'h01 << c});
				rx(AIDR_PATH_RSET, 16'h0001, 8'h00, 5'h00, 9'h008);
			end
		cf = '0;
		$display("t_chan done");
	endtask
	// ticker pace and stamp of a new fault
	task automatic t_stamp();
		logic [31:0] se;
		repeat (100) @(negedge core_clk_i);
		chk("ticker", tick, ne / 40);
		se = ne / 40;
		sm[0] = 1'b1;
		@(negedge core_clk_i);
		for (int b = 0; b < 4; b++)
			rx(AIDR_PATH_SUB, 16'h5005, 8'h13, 5'(b),
				{1'b0, 8'(se >> (8 * b))});
		sm = 7'h00;
		$display("t_stamp done");
	endtask
	// reset, scenarios, verdict
	initial begin
		n_mismatch = 0;
		samples_checked = 0;
		nrst_i = 1'b0;
		sm = 7'h00;
		cf = '0;
		repeat (20) @(negedge core_clk_i);
		nrst_i = 1'b1;
		@(negedge core_clk_i);
		t_const();
		t_refuse();
		t_summary();
		t_chan();
		t_stamp();
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
